// >>> design/smcd_decoder.sv
// Stage command decoder: command gating, pending target, drive launch and position count
`include "smcd_map.svh"
module smcd_decoder import smcd_pkg::*; (
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [31:0]             reg_rdata,
    input  wire logic               operating_mode_selector,
    input  wire logic               limit_sensor,
    input  wire logic               motor_excited,
    input  wire logic               motion_done,
    input  wire logic signed [24:0] done_travel,
    output logic                    resp_valid,
    output logic [15:0]             resp_code,
    output logic [31:0]             resp_data,
    output logic                    mv_start,
    output logic [2:0]              mv_kind,
    output logic signed [24:0]      mv_disp,
    output logic [15:0]             mv_speed,
    output logic [15:0]             mv_ramp,
    output logic                    mv_ramp_en,
    output logic                    mv_backlash,
    output logic                    mv_limit_stop,
    output logic                    mv_stop_slow,
    output logic                    mv_stop_now
);
    function automatic logic in_range(input logic signed [25:0] v);
        return (v <= `SMCD_POS_MAX) && (v >= -`SMCD_POS_MAX);
    endfunction

    smcd_state_t        state_ff;
    smcd_state_t        nxt_state;
    smcd_kind_t         pend_kind_ff;
    smcd_kind_t         mv_kind_ff;
    logic signed [24:0] pos_ff;
    logic signed [24:0] arg_ff;
    logic signed [24:0] pend_val_ff;
    logic [2:0]         pend_idx_ff;
    logic               pend_valid_ff;
    logic               origin_set_ff;
    logic               abort_ff;
    logic [15:0]        speed_ff;
    logic [15:0]        ramp_ff;
    logic [24:0]        rev_ff;
    logic [31:0]        rdata_ff;
    logic               resp_valid_ff;
    logic [15:0]        resp_code_ff;
    logic [31:0]        resp_data_ff;
    logic               mv_start_ff;
    logic signed [24:0] mv_disp_ff;
    logic [15:0]        mv_speed_ff;
    logic [15:0]        mv_ramp_ff;
    logic               mv_ramp_en_ff;
    logic               mv_backlash_ff;
    logic               mv_limit_stop_ff;
    logic               mv_stop_slow_ff;
    logic               mv_stop_now_ff;
    logic signed [24:0] mem_rd;
    logic               red_busy;
    logic               red_done;
    logic signed [24:0] red_res;

    // Command decode
    wire smcd_op_t           op        = smcd_op_t'(reg_wdata[`SMCD_CMD_OP]);
    wire logic [2:0]         btn       = reg_wdata[`SMCD_CMD_BTN];
    wire logic [1:0]         axis      = reg_wdata[`SMCD_CMD_AXIS];
    wire logic               cmd_wr    = reg_wr && (reg_addr == `SMCD_REG_CMD);
    wire logic               is_query  = (op == SMCD_OP_QPOS) || (op == SMCD_OP_QBUSY);
    wire logic               is_stop   = (op == SMCD_OP_STOP) || (op == SMCD_OP_ESTOP);
    wire logic               axis_ok   = (axis == `SMCD_AXIS_ONE) || (axis == `SMCD_AXIS_W);
    wire logic               btn_ok    = (btn >= `SMCD_BTN_MIN) && (btn <= `SMCD_BTN_MAX);
    wire logic               idle      = (state_ff == SMCD_ST_IDLE);
    wire logic               searching = (state_ff == SMCD_ST_ORIGIN);
    wire logic               st_launch = (state_ff == SMCD_ST_LAUNCH);
    wire logic               st_move   = (state_ff == SMCD_ST_MOVE);
    wire logic signed [25:0] arg26     = {arg_ff[24], arg_ff};
    wire logic signed [25:0] rel_sum   = {pos_ff[24], pos_ff} + arg26;

    wire logic accept  = cmd_wr && (operating_mode_selector || is_query);
    wire logic blocked = searching && !is_stop && !is_query;
    wire logic ok_h    = motor_excited && axis_ok && idle;
    wire logic ok_b    = motor_excited && btn_ok && (origin_set_ff || idle);
    wire logic ok_m    = motor_excited && axis_ok && in_range(arg26) && in_range(rel_sum);
    wire logic ok_a    = motor_excited && axis_ok && in_range(arg26);
    wire logic ok_j    = motor_excited && axis_ok && idle;
    wire logic ok_g    = pend_valid_ff && idle;
    wire logic op_ok   = blocked ? 1'b0 :
                         (op == SMCD_OP_ORIGIN) ? ok_h :
                         (op == SMCD_OP_BUTTON) ? ok_b :
                         (op == SMCD_OP_REL)    ? ok_m :
                         (op == SMCD_OP_ABS)    ? ok_a :
                         (op == SMCD_OP_JOG)    ? ok_j :
                         (op == SMCD_OP_GO)     ? ok_g :
                         (is_stop || is_query);
    wire logic done_ok = accept && op_ok;

    wire logic go_origin = done_ok && ((op == SMCD_OP_ORIGIN) ||
                                       (op == SMCD_OP_BUTTON && !origin_set_ff));
    wire logic go_jog    = done_ok && (op == SMCD_OP_JOG);
    wire logic go_launch = done_ok && (op == SMCD_OP_GO);
    wire logic set_pend  = done_ok && ((op == SMCD_OP_BUTTON && origin_set_ff) ||
                                       op == SMCD_OP_REL || op == SMCD_OP_ABS);
    wire logic clr_pend  = go_origin || go_jog || go_launch || (done_ok && is_stop);
    wire logic start_w   = go_origin || go_jog || st_launch;
    wire logic mem_wr    = reg_wr && (reg_addr >= `SMCD_REG_MEM_LO) && (reg_addr <= `SMCD_REG_MEM_HI) &&
                           (reg_addr[1:0] == 2'h0);
    wire logic [7:0]     mem_off   = reg_addr - `SMCD_REG_MEM_LO;
    wire logic signed [24:0] travel_sum = pos_ff + done_travel;
    wire logic           red_start = st_move && motion_done && (mv_kind_ff != SMCD_KIND_MEM);
    wire logic signed [24:0] disp_w =
        (pend_kind_ff == SMCD_KIND_REL) ? pend_val_ff :
        (pend_kind_ff == SMCD_KIND_ABS) ? pend_val_ff - pos_ff : mem_rd - pos_ff;
    wire logic [31:0] status_w = {27'h0000000, red_busy, pend_valid_ff, !idle,
                                  searching, origin_set_ff};
    wire logic [31:0] rd_mux =
        (reg_addr == `SMCD_REG_ARG)    ? {{7{arg_ff[24]}}, arg_ff} :
        (reg_addr == `SMCD_REG_RESP)   ? {16'h0000, resp_code_ff} :
        (reg_addr == `SMCD_REG_RDATA)  ? resp_data_ff :
        (reg_addr == `SMCD_REG_POS)    ? {{7{pos_ff[24]}}, pos_ff} :
        (reg_addr == `SMCD_REG_STATUS) ? status_w :
        (reg_addr == `SMCD_REG_SPEED)  ? {16'h0000, speed_ff} :
        (reg_addr == `SMCD_REG_RAMP)   ? {16'h0000, ramp_ff} :
        (reg_addr == `SMCD_REG_REV)    ? {7'h00, rev_ff} : 32'h00000000;

    smcd_posmem u_mem (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .wr_en      (mem_wr),
        .wr_idx     (mem_off[4:2]),
        .wr_data    (reg_wdata[24:0]),
        .rd_idx     (pend_idx_ff),
        .rd_data_ff (mem_rd)
    );

    smcd_reduce u_red (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .start   (red_start),
        .value   (travel_sum),
        .rev     (rev_ff),
        .busy_ff (red_busy),
        .done_ff (red_done),
        .res_ff  (red_res)
    );

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SMCD_ST_IDLE: begin
                if (go_origin) nxt_state = SMCD_ST_ORIGIN;
                else if (go_jog) nxt_state = SMCD_ST_MOVE;
                else if (go_launch) nxt_state = SMCD_ST_LAUNCH;
            end
            SMCD_ST_LAUNCH: nxt_state = SMCD_ST_MOVE;
            SMCD_ST_ORIGIN: if (motion_done) nxt_state = SMCD_ST_IDLE;
            SMCD_ST_MOVE: begin
                if (motion_done) nxt_state = red_start ? SMCD_ST_REDUCE : SMCD_ST_IDLE;
            end
            SMCD_ST_REDUCE: if (red_done) nxt_state = SMCD_ST_IDLE;
            default: nxt_state = SMCD_ST_IDLE;
        endcase
    end

    // Software settings
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            arg_ff   <= 25'h0000000;
            speed_ff <= `SMCD_SPEED_RST;
            ramp_ff  <= `SMCD_RAMP_RST;
            rev_ff   <= `SMCD_REV_RST;
            rdata_ff <= 32'h00000000;
        end else begin
            if (reg_wr && reg_addr == `SMCD_REG_ARG) arg_ff <= reg_wdata[24:0];
            if (reg_wr && reg_addr == `SMCD_REG_SPEED) speed_ff <= reg_wdata[15:0];
            if (reg_wr && reg_addr == `SMCD_REG_RAMP) ramp_ff <= reg_wdata[15:0];
            if (reg_wr && reg_addr == `SMCD_REG_REV) rev_ff <= reg_wdata[24:0];
            rdata_ff <= reg_rd ? rd_mux : 32'h00000000;
        end
    end

    // Sequencing, pending target and position count
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_ff      <= SMCD_ST_IDLE;
            pend_valid_ff <= 1'b0;
            pend_kind_ff  <= SMCD_KIND_NONE;
            pend_val_ff   <= 25'h0000000;
            pend_idx_ff   <= 3'h0;
            origin_set_ff <= 1'b0;
            abort_ff      <= 1'b0;
            pos_ff        <= 25'h0000000;
        end else begin
            state_ff <= nxt_state;
            if (set_pend) begin
                pend_valid_ff <= 1'b1;
                pend_kind_ff  <= (op == SMCD_OP_BUTTON) ? SMCD_KIND_MEM :
                                 (op == SMCD_OP_REL) ? SMCD_KIND_REL : SMCD_KIND_ABS;
                pend_val_ff   <= arg_ff;
                if (op == SMCD_OP_BUTTON) pend_idx_ff <= btn - 3'h1;
            end else if (clr_pend) begin
                pend_valid_ff <= 1'b0;
            end
            if (go_origin) abort_ff <= 1'b0;
            else if (searching && done_ok && is_stop) abort_ff <= 1'b1;
            if (searching && motion_done && !abort_ff) begin
                pos_ff        <= 25'h0000000;
                origin_set_ff <= 1'b1;
            end else if (st_move && motion_done) begin
                pos_ff <= travel_sum;
            end else if (red_done) begin
                pos_ff <= red_res;
            end
        end
    end

    // Answers and drive requests
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            resp_valid_ff    <= 1'b0;
            resp_code_ff     <= `SMCD_RESP_NONE;
            resp_data_ff     <= 32'h00000000;
            mv_start_ff      <= 1'b0;
            mv_kind_ff       <= SMCD_KIND_NONE;
            mv_disp_ff       <= 25'h0000000;
            mv_speed_ff      <= 16'h0000;
            mv_ramp_ff       <= 16'h0000;
            mv_ramp_en_ff    <= 1'b0;
            mv_backlash_ff   <= 1'b0;
            mv_limit_stop_ff <= 1'b0;
            mv_stop_slow_ff  <= 1'b0;
            mv_stop_now_ff   <= 1'b0;
        end else begin
            resp_valid_ff <= accept;
            if (accept) begin
                resp_code_ff <= is_query ? `SMCD_RESP_NONE : (op_ok ? `SMCD_RESP_OK : `SMCD_RESP_NG);
                resp_data_ff <= (op == SMCD_OP_QPOS) ? {{7{pos_ff[24]}}, pos_ff} :
                                (op == SMCD_OP_QBUSY) ? (idle ? `SMCD_ANS_READY : `SMCD_ANS_BUSY) : 32'h00000000;
            end
            mv_start_ff <= start_w;
            if (start_w) begin
                mv_kind_ff       <= go_origin ? SMCD_KIND_ORIGIN : go_jog ? SMCD_KIND_JOG : pend_kind_ff;
                mv_disp_ff       <= st_launch ? disp_w : 25'h0000000;
                mv_speed_ff      <= go_jog ? `SMCD_MIN_SPEED : speed_ff;
                mv_ramp_ff       <= ramp_ff;
                mv_ramp_en_ff    <= !go_jog;
                mv_backlash_ff   <= st_launch && (pend_kind_ff == SMCD_KIND_MEM);
                mv_limit_stop_ff <= !go_jog;
            end
            mv_stop_slow_ff <= done_ok && (op == SMCD_OP_STOP);
            mv_stop_now_ff  <= (done_ok && op == SMCD_OP_ESTOP) || (searching && limit_sensor);
        end
    end

    assign reg_rdata     = rdata_ff;
    assign resp_valid    = resp_valid_ff;
    assign resp_code     = resp_code_ff;
    assign resp_data     = resp_data_ff;
    assign mv_start      = mv_start_ff;
    assign mv_kind       = mv_kind_ff;
    assign mv_disp       = mv_disp_ff;
    assign mv_speed      = mv_speed_ff;
    assign mv_ramp       = mv_ramp_ff;
    assign mv_ramp_en    = mv_ramp_en_ff;
    assign mv_backlash   = mv_backlash_ff;
    assign mv_limit_stop = mv_limit_stop_ff;
    assign mv_stop_slow  = mv_stop_slow_ff;
    assign mv_stop_now   = mv_stop_now_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    wire logic [24:0] pos_mag = pos_ff[24] ? -pos_ff : pos_ff;

    sequence s_mem_go;
        go_launch && (pend_kind_ff == SMCD_KIND_MEM);
    endsequence
    sequence s_mem_launch;
        mv_start && mv_backlash && (mv_kind == SMCD_KIND_MEM);
    endsequence

    AST_MODE_IGNORE: assert property (cmd_wr && !operating_mode_selector && !is_query |=> !resp_valid)
        else $error("command answered outside serial mode");
    AST_JOG_NO_LIMIT: assert property (mv_start && mv_kind == SMCD_KIND_JOG |-> !mv_limit_stop && !mv_ramp_en)
        else $error("jog launched with limit stop or ramp");
    AST_REDUCE_IN_REV: assert property (red_done && rev_ff != 25'h0000000 |=> pos_mag < rev_ff)
        else $error("position not folded into one revolution");
    AST_ORIGIN_ZERO: assert property (searching && motion_done && !abort_ff |=>
        pos_ff == 25'h0000000 && origin_set_ff)
        else $error("origin search did not zero position");
    AST_SEARCH_REJECT: assert property (accept && searching && op == SMCD_OP_REL |=>
        resp_valid && resp_code == `SMCD_RESP_NG)
        else $error("command accepted during origin search");
    AST_ORIGIN_SPEED: assert property (go_origin |=>
        mv_start && mv_speed == $past(speed_ff) && mv_ramp == $past(ramp_ff))
        else $error("origin search ignores speed settings");
    AST_LIMIT_STOP: assert property (searching && limit_sensor |=> mv_stop_now)
        else $error("no abrupt stop at limit during search");
    AST_EXCITE_H: assert property (accept && op == SMCD_OP_ORIGIN && !motor_excited |=>
        resp_code == `SMCD_RESP_NG && !(mv_start && mv_kind == SMCD_KIND_ORIGIN))
        else $error("origin search started while unexcited");
    AST_MEM_BACKLASH: assert property (s_mem_go |=> resp_code == `SMCD_RESP_OK ##1 s_mem_launch)
        else $error("memory move launched without backlash");
    AST_REL_PLAIN: assert property (mv_start && mv_kind == SMCD_KIND_REL |-> !mv_backlash && mv_ramp_en)
        else $error("relative move with backlash or no ramp");
    AST_JOG_CLEARS: assert property (go_jog |=> !pend_valid_ff ##1 mv_speed == `SMCD_MIN_SPEED)
        else $error("jog kept pending target");
    AST_GO_NO_PEND: assert property (accept && op == SMCD_OP_GO && !pend_valid_ff |=>
        resp_code == `SMCD_RESP_NG && !st_launch)
        else $error("drive without target started motion");
endmodule

// >>> design/smcd_map.svh
// Register offsets, field positions, reset values and fixed codes of the stage command decoder
`ifndef SMCD_MAP_SVH
`define SMCD_MAP_SVH

`define SMCD_REG_CMD      8'h00
`define SMCD_REG_ARG      8'h04
`define SMCD_REG_RESP     8'h08
`define SMCD_REG_RDATA    8'h0C
`define SMCD_REG_POS      8'h10
`define SMCD_REG_STATUS   8'h14
`define SMCD_REG_SPEED    8'h18
`define SMCD_REG_RAMP     8'h1C
`define SMCD_REG_REV      8'h20
`define SMCD_REG_MEM_LO   8'h24
`define SMCD_REG_MEM_HI   8'h34

`define SMCD_CMD_OP       3:0
`define SMCD_CMD_BTN      6:4
`define SMCD_CMD_AXIS     9:8

`define SMCD_AXIS_ONE     2'h1
`define SMCD_AXIS_W       2'h2
`define SMCD_BTN_MIN      3'h1
`define SMCD_BTN_MAX      3'h5

`define SMCD_POS_MAX      26'sh0FFFFFE
`define SMCD_SPEED_RST    16'h0064
`define SMCD_RAMP_RST     16'h0032
`define SMCD_REV_RST      25'h0000FA0
`define SMCD_MIN_SPEED    16'h0001

`define SMCD_RESP_OK      16'h4F4B
`define SMCD_RESP_NG      16'h4E47
`define SMCD_RESP_NONE    16'h0000
`define SMCD_ANS_BUSY     32'h00000042
`define SMCD_ANS_READY    32'h00000052

`define SMCD_RED_STEPS    5'h19

`endif

// >>> design/smcd_pkg.sv
// Types shared by the stage command decoder files
package smcd_pkg;

    typedef enum logic [3:0] {
        SMCD_OP_ORIGIN = 4'h1,
        SMCD_OP_BUTTON = 4'h2,
        SMCD_OP_REL    = 4'h3,
        SMCD_OP_ABS    = 4'h4,
        SMCD_OP_JOG    = 4'h5,
        SMCD_OP_GO     = 4'h6,
        SMCD_OP_STOP   = 4'h7,
        SMCD_OP_ESTOP  = 4'h8,
        SMCD_OP_QPOS   = 4'h9,
        SMCD_OP_QBUSY  = 4'hA
    } smcd_op_t;

    typedef enum logic [2:0] {
        SMCD_KIND_NONE   = 3'h0,
        SMCD_KIND_ORIGIN = 3'h1,
        SMCD_KIND_REL    = 3'h2,
        SMCD_KIND_ABS    = 3'h3,
        SMCD_KIND_JOG    = 3'h4,
        SMCD_KIND_MEM    = 3'h5
    } smcd_kind_t;

    typedef enum logic [2:0] {
        SMCD_ST_IDLE,
        SMCD_ST_LAUNCH,
        SMCD_ST_ORIGIN,
        SMCD_ST_MOVE,
        SMCD_ST_REDUCE
    } smcd_state_t;

endpackage

// >>> design/smcd_posmem.sv
// Five-entry memorized position store with registered read
module smcd_posmem (
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    input  wire logic               wr_en,
    input  wire logic [2:0]         wr_idx,
    input  wire logic signed [24:0] wr_data,
    input  wire logic [2:0]         rd_idx,
    output logic signed [24:0]      rd_data_ff
);
    logic signed [24:0] mem_ff [0:4];

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 5; i++) begin
                mem_ff[i] <= 25'h0000000;
            end
            rd_data_ff <= 25'h0000000;
        end else begin
            if (wr_en && wr_idx < 3'h5) begin
                mem_ff[wr_idx] <= wr_data;
            end
            rd_data_ff <= (rd_idx < 3'h5) ? mem_ff[rd_idx] : 25'h0000000;
        end
    end
endmodule

// >>> design/smcd_reduce.sv
// Sequential reduction of a position count into one revolution
`include "smcd_map.svh"
module smcd_reduce (
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    input  wire logic               start,
    input  wire logic signed [24:0] value,
    input  wire logic [24:0]        rev,
    output logic                    busy_ff,
    output logic                    done_ff,
    output logic signed [24:0]      res_ff
);
    logic [24:0] mag_ff;
    logic [25:0] rem_ff;
    logic [4:0]  cnt_ff;
    logic        neg_ff;
    logic [25:0] shifted;
    logic [25:0] nxt_rem;

    assign shifted = {rem_ff[24:0], mag_ff[24]};
    assign nxt_rem = (shifted >= {1'b0, rev}) ? shifted - {1'b0, rev} : shifted;

    // Restoring remainder on the magnitude, sign put back at the end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            res_ff  <= 25'h0000000;
            mag_ff  <= 25'h0000000;
            rem_ff  <= 26'h0000000;
            cnt_ff  <= 5'h00;
            neg_ff  <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (start && rev == 25'h0000000) begin
                res_ff  <= value;
                done_ff <= 1'b1;
            end else if (start) begin
                mag_ff  <= value[24] ? -value : value;
                neg_ff  <= value[24];
                rem_ff  <= 26'h0000000;
                cnt_ff  <= `SMCD_RED_STEPS;
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                rem_ff <= nxt_rem;
                mag_ff <= {mag_ff[23:0], 1'b0};
                cnt_ff <= cnt_ff - 5'h01;
                if (cnt_ff == 5'h01) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                    res_ff  <= neg_ff ? -nxt_rem[24:0] : nxt_rem[24:0];
                end
            end
        end
    end
endmodule

// >>> sim/smcd_motion_model.sv
// Pulse generator stand-in: answers each launch with one done pulse
module smcd_motion_model (
    input  wire logic               ref_clk,
    input  wire logic               mv_start,
    input  wire logic signed [24:0] mv_disp,
    output logic                    motion_done,
    output logic signed [24:0]      done_travel
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial begin
        motion_done = 1'b0;
        done_travel = 25'sh0;
    end
    // Travel word is only valid with the pulse; garbage otherwise
    always @(posedge ref_clk) begin
        motion_done <= 1'b0;
        done_travel <= ~done_travel;
        if (mv_start)
            cnt <= 20;
        else if (cnt > 0)
            cnt <= cnt - 1;
        if (cnt == 1) begin
            motion_done <= 1'b1;
            done_travel <= mv_disp;
        end
    end
endmodule

// >>> sim/stage_move_command_decoder_tb.sv
// Self-checking bench of the stage command decoder
`include "smcd_map.svh"
module stage_move_command_decoder_tb import smcd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, sys_rst = 1, wr = 0, rd = 0, mode = 0, lim = 0, exc = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wd = 32'h0, rdat, rdt, rsd;
    logic rv, ms, mn, bl, ls, re, mdn, ss;
    logic [15:0] rc, spd, rmp;
    localparam logic [15:0] new_speed = 16'h0123;
    localparam logic [15:0] new_ramp = 16'h0045;
    logic [2:0] kd;
    logic signed [24:0] dsp, trv;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    smcd_decoder dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdat), .operating_mode_selector(mode), .limit_sensor(lim),
        .motor_excited(exc), .motion_done(mdn), .done_travel(trv), .resp_valid(rv), .resp_code(rc),
        .resp_data(rsd), .mv_start(ms), .mv_kind(kd), .mv_disp(dsp), .mv_speed(spd), .mv_ramp(rmp),
        .mv_ramp_en(re), .mv_backlash(bl), .mv_limit_stop(ls), .mv_stop_slow(ss), .mv_stop_now(mn));
    smcd_motion_model pg (.ref_clk(ref_clk), .mv_start(ms), .mv_disp(dsp), .motion_done(mdn),
        .done_travel(trv));
    initial forever #25 ref_clk = ~ref_clk;
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wrt(logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rdr(logic [7:0] a);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 rdt = rdat;
    endtask
    task automatic rdc(logic [7:0] a, logic [31:0] exp);
        rdr(a);
        chk("reg_rdata", exp, rdt);
    endtask
    // Command write, then the answer one cycle later
    task automatic cmd(logic [31:0] w, logic v, logic [15:0] c);
        wrt(8'h00, w);
        #1 chk("resp_valid", v, rv);
        if (v)
            chk("resp_code", c, rc);
    endtask
    task automatic lnch(logic [2:0] k, logic [24:0] d, logic b, logic j);
        int n = 0;
        while (ms !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk("mv_start", 1, ms);
        chk("mv_kind", k, kd);
        chk("mv_disp", d, dsp);
        chk("mv_backlash", b, bl);
        chk("mv_limit_stop", !j, ls);
        chk("mv_ramp_en", !j, re);
        chk("mv_speed", j ? `SMCD_MIN_SPEED : new_speed, spd);
        chk("mv_ramp", new_ramp, rmp);
    endtask
    task automatic idle();
        int n = 0;
        do begin
            rdr(8'h14);
            n++;
        end while (rdt[2] !== 1'b0 && n < 200);
        chk("status_busy", 0, rdt[2]);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rdc(8'h18, `SMCD_SPEED_RST);
        rdc(8'h1C, `SMCD_RAMP_RST);
        rdc(8'h3C, 0);
        wrt(8'h18, new_speed);
        wrt(8'h1C, new_ramp);
        rdc(8'h18, new_speed);
        cmd(32'h101, 0, 0);
        cmd(32'h009, 1, `SMCD_RESP_NONE);
        @(posedge ref_clk) mode <= 1'b1;
        cmd(32'h101, 1, `SMCD_RESP_NG);
        cmd(32'h103, 1, `SMCD_RESP_NG);
        cmd(32'h006, 1, `SMCD_RESP_NG);
        @(posedge ref_clk) exc <= 1'b1;
        cmd(32'h101, 1, `SMCD_RESP_OK);
        lnch(3'h1, 0, 0, 0);
        cmd(32'h103, 1, `SMCD_RESP_NG);
        cmd(32'h00A, 1, `SMCD_RESP_NONE);
        chk("resp_data", `SMCD_ANS_BUSY, rsd);
        @(posedge ref_clk) lim <= 1'b1;
        repeat (2) @(posedge ref_clk);
        lim <= 1'b0;
        #1 chk("mv_stop_now", 1, mn);
        idle();
        chk("origin_set", 1, rdt[0]);
        rdc(8'h10, 0);
        wrt(8'h20, 150);
        wrt(8'h04, 100);
        cmd(32'h103, 1, `SMCD_RESP_OK);
        wrt(8'h04, 200);
        cmd(32'h203, 1, `SMCD_RESP_OK);
        cmd(32'h006, 1, `SMCD_RESP_OK);
        lnch(3'h2, 200, 0, 0);
        idle();
        rdc(8'h10, 50);
        wrt(8'h04, 32'h00FFFFFF);
        cmd(32'h103, 1, `SMCD_RESP_NG);
        wrt(8'h04, 32'h00FFFFFE);
        cmd(32'h103, 1, `SMCD_RESP_NG);
        wrt(8'h04, 10);
        cmd(32'h103, 1, `SMCD_RESP_OK);
        cmd(32'h007, 1, `SMCD_RESP_OK);
        chk("mv_stop_slow", 1, ss);
        cmd(32'h006, 1, `SMCD_RESP_NG);
        cmd(32'h062, 1, `SMCD_RESP_NG);
        wrt(8'h28, 300);
        cmd(32'h022, 1, `SMCD_RESP_OK);
        cmd(32'h006, 1, `SMCD_RESP_OK);
        lnch(3'h5, 250, 1, 0);
        idle();
        rdc(8'h10, 300);
        cmd(32'h205, 1, `SMCD_RESP_OK);
        lnch(3'h4, 0, 0, 1);
        idle();
        rdc(8'h10, 0);
        final_report();
    end
endmodule
